// ==== segment_table_walker.sv ====
// Our own choices: the address-and-strobe port and the address map.
module segment_table_walker
    import seg_walk_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic walk_request,
    input wire logic [35:0] walk_effective_segment_id,
    output logic walk_busy,
    output logic walk_done,
    output logic walk_hit,
    output logic walk_miss,
    output logic [127:0] walk_entry,
    output logic [3:0] walk_slot,
    output logic mem_read,
    output logic [63:0] mem_addr,
    output logic [3:0] mem_attributes,
    input wire logic mem_valid,
    input wire logic [127:0] mem_rdata,
    input wire logic slb_invalidate_one,
    input wire logic slb_invalidate_all,
    input wire logic [3:0] slb_index,
    output logic machine_check
);
    logic [63:0] segment_table_base_reg;
    logic [1:0] control_reg;
    walk_state_type state_reg;
    logic [35:0] effective_segment_id_reg;
    logic [4:0] slot_reg;
    logic [63:0] primary_addr_reg;
    logic [63:0] secondary_addr_reg;
    logic [4:0] primary_hash;
    logic [4:0] secondary_hash;
    logic base_valid_flag;
    logic bridge_mode;
    logic [127:0] lookaside_entry;
    logic lookaside_valid;
    logic [31:0] status_word;

    assign bridge_mode = control_reg[BRIDGE_BIT];
    // With bridge mode off, the valid flag is taken as 1 for translation.
    assign base_valid_flag = bridge_mode ? segment_table_base_reg[VALID_BIT] : 1'b1;

    seg_hash hash_unit (
        .effective_segment_id(walk_effective_segment_id),
        .primary_hash(primary_hash),
        .secondary_hash(secondary_hash)
    );

    seg_lookaside lookaside_unit (
        .clock(clock),
        .rst(rst),
        .write_enable(walk_hit && state_reg == DONE && !bridge_mode),
        .write_index(slb_index),
        .write_entry(walk_entry),
        .invalidate_one(slb_invalidate_one),
        .invalidate_all(slb_invalidate_all),
        .lookup_index(bridge_mode ? walk_effective_segment_id[3:0] : slb_index),
        .lookup_entry(lookaside_entry),
        .lookup_valid(lookaside_valid)
    );

    always_ff @(posedge clock) begin
        if (rst) begin
            segment_table_base_reg <= BASE_RESET;
        end else if (reg_write && reg_addr == BASE_LO_ADDR) begin
            segment_table_base_reg[31:0] <= {reg_wdata[31:12], 12'h000} |
                {20'h00000, 11'h000, reg_wdata[0]};
        end else if (reg_write && reg_addr == BASE_HI_ADDR) begin
            segment_table_base_reg[63:32] <= reg_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            control_reg <= CONTROL_RESET;
        end else if (reg_write && reg_addr == CONTROL_ADDR) begin
            control_reg <= reg_wdata[1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            machine_check <= 1'b0;
        end else if (reg_write && reg_addr == BASE_LO_ADDR && |reg_wdata[11:1]) begin
            machine_check <= 1'b1;
        end else if (reg_write && reg_addr == STATUS_ADDR) begin
            machine_check <= 1'b0;
        end
    end

    assign status_word = {24'h000000, machine_check, walk_miss, walk_hit, walk_busy,
        1'b0, state_reg};

    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_read) begin
            case (reg_addr)
                BASE_LO_ADDR: reg_rdata <= segment_table_base_reg[31:0];
                BASE_HI_ADDR: reg_rdata <= segment_table_base_reg[63:32];
                STATUS_ADDR: reg_rdata <= status_word;
                CONTROL_ADDR: reg_rdata <= {30'h0, control_reg};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= IDLE;
            effective_segment_id_reg <= '0;
            slot_reg <= '0;
            primary_addr_reg <= '0;
            secondary_addr_reg <= '0;
            walk_busy <= 1'b0;
            walk_done <= 1'b0;
            walk_hit <= 1'b0;
            walk_miss <= 1'b0;
            walk_entry <= '0;
            walk_slot <= '0;
        end else begin
            walk_done <= 1'b0;
            case (state_reg)
                IDLE: begin
                    if (walk_request) begin
                        effective_segment_id_reg <= walk_effective_segment_id;
                        walk_busy <= 1'b1;
                        walk_hit <= 1'b0;
                        walk_miss <= 1'b0;
                        slot_reg <= '0;
                        primary_addr_reg <= group_address(segment_table_base_reg[63:12],
                            primary_hash);
                        secondary_addr_reg <= group_address(segment_table_base_reg[63:12],
                            secondary_hash);
                        if (bridge_mode && base_valid_flag == 1'b0) begin
                            state_reg <= BRIDGE;
                        end else if (!base_valid_flag) begin
                            state_reg <= DONE;
                            walk_miss <= 1'b1;
                        end else begin
                            state_reg <= REQUEST;
                        end
                    end
                end
                BRIDGE: begin
                    // Lookaside read lands one cycle after the request.
                    if (lookaside_valid && effective_segment_id_reg[35:BRIDGE_EFFECTIVE_SEGMENT_ID_BITS] == '0) begin
                        walk_hit <= 1'b1;
                        walk_entry <= lookaside_entry;
                        walk_slot <= effective_segment_id_reg[3:0];
                    end else begin
                        walk_miss <= 1'b1;
                    end
                    state_reg <= DONE;
                end
                REQUEST: begin
                    state_reg <= WAIT_DATA;
                end
                WAIT_DATA: begin
                    if (mem_valid) begin
                        if (entry_hit(mem_rdata, effective_segment_id_reg)) begin
                            walk_hit <= 1'b1;
                            walk_entry <= mem_rdata;
                            walk_slot <= slot_reg[3:0];
                            state_reg <= DONE;
                        end else if (slot_reg == 5'(2 * SLOT_COUNT - 1)) begin
                            walk_miss <= 1'b1;
                            state_reg <= DONE;
                        end else begin
                            slot_reg <= slot_reg + 5'h01;
                            state_reg <= REQUEST;
                        end
                    end
                end
                DONE: begin
                    walk_done <= 1'b1;
                    walk_busy <= 1'b0;
                    state_reg <= IDLE;
                end
                default: state_reg <= IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mem_read <= 1'b0;
            mem_addr <= '0;
            mem_attributes <= WALK_ATTRIBUTES;
        end else begin
            mem_read <= (state_reg == REQUEST);
            mem_attributes <= WALK_ATTRIBUTES;
            if (state_reg == REQUEST) begin
                // Primary group slots 0-7 first, then secondary slots 0-7.
                mem_addr <= (slot_reg[SLOT_BITS] ? secondary_addr_reg : primary_addr_reg) |
                    {57'h0, slot_reg[SLOT_BITS-1:0], 4'h0};
            end
        end
    end
endmodule

// ==== seg_walk_pkg.sv ====
package seg_walk_pkg;
    localparam int unsigned ADDR_WIDTH = 8;
    localparam int unsigned PHYS_WIDTH = 52;
    localparam logic [7:0] BASE_LO_ADDR = 8'h00;
    localparam logic [7:0] BASE_HI_ADDR = 8'h04;
    localparam logic [7:0] STATUS_ADDR = 8'h08;
    localparam logic [7:0] CONTROL_ADDR = 8'h0c;
    localparam logic [63:0] BASE_RESET = 64'h0000_0000_0000_0000;
    localparam logic [1:0] CONTROL_RESET = 2'h0;
    localparam int unsigned VALID_BIT = 0;
    localparam int unsigned BRIDGE_BIT = 1;
    localparam int unsigned ORIGIN_BITS = 52;
    localparam int unsigned HASH_BITS = 5;
    localparam int unsigned SLOT_BITS = 3;
    localparam int unsigned ENTRY_BYTES_LOG = 4;
    localparam int unsigned SLOT_COUNT = 8;
    localparam int unsigned LOOKASIDE_COUNT = 16;
    localparam int unsigned EFFECTIVE_SEGMENT_ID_BITS = 36;
    localparam int unsigned BRIDGE_EFFECTIVE_SEGMENT_ID_BITS = 4;
    localparam logic [3:0] WALK_ATTRIBUTES = 4'h2;
    localparam int unsigned ENTRY_VALID_BIT = 7;
    localparam int unsigned ENTRY_EFFECTIVE_SEGMENT_ID_LSB = 28;

    typedef enum logic [2:0] {
        IDLE = 3'b000,
        REQUEST = 3'b001,
        WAIT_DATA = 3'b011,
        DONE = 3'b010,
        BRIDGE = 3'b110
    } walk_state_type;

    function automatic logic [63:0] group_address(input logic [51:0] origin,
            input logic [4:0] hash);
        group_address = {origin, hash, 7'h00};
    endfunction

    function automatic logic entry_hit(input logic [127:0] entry, input logic [35:0] effective_segment_id);
        entry_hit = entry[ENTRY_VALID_BIT] && (entry[63:ENTRY_EFFECTIVE_SEGMENT_ID_LSB] == effective_segment_id);
    endfunction
endpackage

// ==== seg_lookaside.sv ====
module seg_lookaside
    import seg_walk_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic write_enable,
    input wire logic [3:0] write_index,
    input wire logic [127:0] write_entry,
    input wire logic invalidate_one,
    input wire logic invalidate_all,
    input wire logic [3:0] lookup_index,
    output logic [127:0] lookup_entry,
    output logic lookup_valid
);
    logic [127:0] entry_mem [LOOKASIDE_COUNT];
    logic [LOOKASIDE_COUNT-1:0] valid_reg;

    always_ff @(posedge clock) begin
        if (write_enable) begin
            entry_mem[write_index] <= write_entry;
        end
    end

    always_ff @(posedge clock) begin
        if (rst || invalidate_all) begin
            valid_reg <= '0;
        end else if (invalidate_one) begin
            valid_reg[write_index] <= 1'b0;
        end else if (write_enable) begin
            valid_reg[write_index] <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        lookup_entry <= entry_mem[lookup_index];
        lookup_valid <= valid_reg[lookup_index];
    end
endmodule

// ==== seg_hash.sv ====
module seg_hash
    import seg_walk_pkg::*;
(
    input wire logic [35:0] effective_segment_id,
    output logic [4:0] primary_hash,
    output logic [4:0] secondary_hash
);
    assign primary_hash = effective_segment_id[HASH_BITS-1:0];
    assign secondary_hash = ~effective_segment_id[HASH_BITS-1:0];
endmodule

// ==== seg_mem_model.sv ====
module seg_mem_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic mem_read,
    input wire logic [63:0] mem_addr,
    input wire logic [7:0] lat,
    output logic mem_valid,
    output logic [127:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [127:0] mem [256];
    logic [7:0] cnt_reg;
    logic [7:0] idx_reg;
    logic pend_reg;
    always_ff @(posedge clock) begin
        mem_valid <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (rst) begin
            pend_reg <= 1'b0;
            mem_rdata <= {4{32'h5a5a_c3c3}};
        end else if (mem_read) begin
            pend_reg <= 1'b1;
            cnt_reg <= lat;
            idx_reg <= mem_addr[11:4];
        end else if (pend_reg && cnt_reg == 8'h00) begin
            pend_reg <= 1'b0;
            mem_valid <= 1'b1;
            mem_rdata <= mem[idx_reg];
        end else begin
            cnt_reg <= cnt_reg - 8'h01;
        end
    end
endmodule

// ==== segment_table_walker_chk.sv ====
module segment_table_walker_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic walk_request,
    input wire logic [35:0] walk_effective_segment_id,
    input wire logic walk_busy,
    input wire logic walk_done,
    input wire logic walk_hit,
    input wire logic walk_miss,
    input wire logic [127:0] walk_entry,
    input wire logic mem_read,
    input wire logic [63:0] mem_addr,
    input wire logic [3:0] mem_attributes,
    input wire logic mem_valid,
    input wire logic [127:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [35:0] effective_segment_id_reg;
    logic hit_now;
    logic last_slot;
    logic [7:0] next_idx;
    assign hit_now = mem_rdata[7] && mem_rdata[63:28] == effective_segment_id_reg;
    assign last_slot = mem_addr[6:4] == 3'h7 && mem_addr[11:7] == ~effective_segment_id_reg[4:0];
    assign next_idx = mem_addr[6:4] == 3'h7 ? {~mem_addr[11:7], 3'h0} : mem_addr[11:4] + 8'h01;
    always_ff @(posedge clock) begin
        if (rst) effective_segment_id_reg <= 36'h0;
        else if (walk_request && !walk_busy) effective_segment_id_reg <= walk_effective_segment_id;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence accepted_s; walk_request && !walk_busy; endsequence
    sequence miss_data_s; mem_valid && !hit_now; endsequence
    attr_fixed_a: assert property (mem_attributes == 4'h2)
        else $error("walk read attributes wrong");
    group_addr_a: assert property (mem_read |-> mem_addr[3:0] == 4'h0 &&
        (mem_addr[11:7] == effective_segment_id_reg[4:0] || mem_addr[11:7] == ~effective_segment_id_reg[4:0]))
        else $error("walk read address off group");
    first_slot_a: assert property (accepted_s ##2 mem_read |->
        mem_addr[11:4] == {effective_segment_id_reg[4:0], 3'h0}) else $error("first read not primary slot 0");
    next_slot_a: assert property (miss_data_s and !last_slot |->
        ##2 mem_read && mem_addr[11:4] == $past(next_idx, 2)) else $error("next slot wrong");
    hit_done_a: assert property (mem_valid && hit_now |-> ##1 walk_hit ##1
        walk_done && walk_entry == $past(mem_rdata, 2)) else $error("hit not delivered");
    miss_done_a: assert property (miss_data_s and last_slot |->
        ##2 walk_done && walk_miss && !walk_hit) else $error("miss not reported");
    done_pulse_a: assert property (walk_done |=> !walk_done && !walk_busy)
        else $error("done not a single pulse");
    idle_quiet_a: assert property (!walk_busy |-> !mem_read)
        else $error("read outside a walk");
endmodule
bind segment_table_walker segment_table_walker_chk chk_u (.clock, .rst, .walk_request,
    .walk_effective_segment_id, .walk_busy, .walk_done, .walk_hit, .walk_miss, .walk_entry, .mem_read,
    .mem_addr, .mem_attributes, .mem_valid, .mem_rdata);

// ==== tb_segment_table_walker.sv ====
module tb_segment_table_walker;
    timeunit 1ns;
    timeprecision 1ps;
    import seg_walk_pkg::*;
    logic clock, rst, reg_write, reg_read, walk_request, walk_busy, walk_done, walk_hit;
    logic walk_miss, mem_read, mem_valid, slb_invalidate_one, slb_invalidate_all, machine_check;
    logic [7:0] reg_addr, lat;
    logic [31:0] reg_wdata, reg_rdata;
    logic [35:0] walk_effective_segment_id;
    logic [127:0] walk_entry, mem_rdata;
    logic [3:0] walk_slot, mem_attributes, slb_index;
    logic [63:0] mem_addr;
    int err_total, n_checks, n_reads;
    segment_table_walker dut_u (.clock, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .walk_request, .walk_effective_segment_id, .walk_busy, .walk_done, .walk_hit, .walk_miss,
        .walk_entry, .walk_slot, .mem_read, .mem_addr, .mem_attributes, .mem_valid, .mem_rdata,
        .slb_invalidate_one, .slb_invalidate_all, .slb_index, .machine_check);
    seg_mem_model mem_u (.clock, .rst, .mem_read, .mem_addr, .lat, .mem_valid, .mem_rdata);
    function automatic logic [127:0] ent(input logic [35:0] effective_segment_id, input logic v);
        ent = {64'h1111_2222_3333_4444, effective_segment_id, 20'h0, v, 7'h0};
    endfunction
    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (err_total == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
        @(posedge clock);
        reg_write <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        {reg_addr, reg_read} <= {a, 1'b1};
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        check(what, reg_rdata, exp);
    endtask
    task automatic walk_chk(input string what, input logic [35:0] effective_segment_id, input logic hit,
            input int reads);
        int n;
        n = 0;
        n_reads = 0;
        @(posedge clock);
        {walk_request, walk_effective_segment_id} <= {1'b1, effective_segment_id};
        @(posedge clock);
        walk_request <= 1'b0;
        while (walk_done !== 1'b1 && n < 300) begin
            @(posedge clock);
            #1;
            n++;
        end
        check(what, {walk_done, walk_hit, walk_miss}, {1'b1, hit, ~hit});
        check("read count", n_reads, reads);
    endtask
    always @(posedge clock) if (mem_read === 1'b1) n_reads++;
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        finish_test();
    end
    initial begin
        {rst, reg_write, reg_read, walk_request, slb_invalidate_one} = 5'h10;
        {reg_addr, reg_wdata, walk_effective_segment_id, lat, slb_index} = '0;
        slb_invalidate_all = 1'b1;
        for (int i = 0; i < 256; i++) mem_u.mem[i] = '0;
        mem_u.mem[8'h98] = ent(36'h1, 1'b1);
        mem_u.mem[8'h99] = ent(36'h0_abcd_e013, 1'b0);
        mem_u.mem[8'h9b] = ent(36'h0_abcd_e013, 1'b1);
        mem_u.mem[8'hd2] = ent(36'h5, 1'b1);
        repeat (16) @(posedge clock);
        {rst, slb_invalidate_all, slb_index} <= {2'h0, 4'h5};
        #1;
        check("attributes", mem_attributes, 4'h2);
        rd_chk("base lo reset", BASE_LO_ADDR, BASE_RESET[31:0]);
        wr(BASE_LO_ADDR, 32'h3456_7003);
        check("machine check", machine_check, 1'b1);
        rd_chk("base lo", BASE_LO_ADDR, 32'h3456_7001);
        wr(STATUS_ADDR, 32'h0);
        check("machine check clear", machine_check, 1'b0);
        wr(BASE_HI_ADDR, 32'h0000_0012);
        rd_chk("base hi", BASE_HI_ADDR, 32'h0000_0012);
        rd_chk("unmapped", 8'h40, 32'h0);
        walk_chk("walk primary", 36'h0_abcd_e013, 1'b1, 4);
        check("slot primary", walk_slot, 4'h3);
        check("entry primary", walk_entry, ent(36'h0_abcd_e013, 1'b1));
        lat = 8'h03;
        walk_chk("walk secondary", 36'h5, 1'b1, 11);
        check("slot secondary", walk_slot, 4'ha);
        check("entry secondary", walk_entry, ent(36'h5, 1'b1));
        walk_chk("walk miss", 36'h7, 1'b0, 16);
        rd_chk("status miss", STATUS_ADDR, 32'h0000_0040);
        wr(CONTROL_ADDR, 32'h2);
        rd_chk("control", CONTROL_ADDR, 32'h0000_0002);
        wr(BASE_LO_ADDR, 32'h3456_7000);
        walk_chk("bridge hit", 36'h5, 1'b1, 0);
        check("slot bridge", walk_slot, 4'h5);
        check("entry bridge", walk_entry, ent(36'h5, 1'b1));
        @(posedge clock);
        slb_invalidate_one <= 1'b1;
        @(posedge clock);
        slb_invalidate_one <= 1'b0;
        walk_chk("bridge miss", 36'h5, 1'b0, 0);
        wr(BASE_LO_ADDR, 32'h3456_7001);
        walk_chk("bridge table walk", 36'h0_abcd_e013, 1'b1, 4);
        check("slot bridge walk", walk_slot, 4'h3);
        finish_test();
    end
endmodule
